// ---- verilog/wtm_pkg.sv ----
// Purpose: Constants shared by the wake-up timer and measurement registers.
// Assumes: 50 MHz system clock, 8-bit register port.
// Notes:   Offsets are byte addresses of the 8-bit register port.
`default_nettype none
package wtm_pkg;
	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// Register offsets.
	localparam logic [7:0] OFS_GAIN  = 8'h2d;
	localparam logic [7:0] OFS_RSVA  = 8'h2e;
	localparam logic [7:0] OFS_RSVB  = 8'h2f;
	localparam logic [7:0] OFS_AUX   = 8'h30;
	localparam logic [7:0] OFS_CTRL  = 8'h31;
	localparam logic [7:0] OFS_ACFG  = 8'h32;
	localparam logic [7:0] OFS_AREF  = 8'h33;
	// Reset value of every register.
	localparam logic [7:0] REG_RESET = 8'h00;
	// Wake-up timer control fields.
	localparam int CTRL_RANGE   = 7;
	localparam int CTRL_TMO_HI  = 6;
	localparam int CTRL_TMO_LO  = 4;
	localparam int CTRL_TO_IRQ  = 3;
	localparam int CTRL_AMP     = 2;
	localparam int CTRL_PH      = 1;
	localparam int CTRL_RSVD    = 0;
	// Amplitude configuration fields.
	localparam int ACFG_DLT_HI  = 7;
	localparam int ACFG_DLT_LO  = 4;
	localparam int ACFG_INCL    = 3;
	localparam int ACFG_WT_HI   = 2;
	localparam int ACFG_WT_LO   = 1;
	localparam int ACFG_SEL     = 0;
	// Weight 4 is a shift of two; each code step doubles it.
	localparam logic [2:0] AVG_SHIFT_BASE = 3'h2;
	// Timer step lengths in milliseconds and the clock rate.
	localparam int CLK_HZ       = 50_000_000;
	localparam int STEP_LONG_MS = 100;
	localparam int STEP_SHRT_MS = 10;
	localparam int MS_PER_S     = 1000;
	localparam int STEP_LONG_CYC = STEP_LONG_MS * (CLK_HZ / MS_PER_S);
	localparam int STEP_SHRT_CYC = STEP_SHRT_MS * (CLK_HZ / MS_PER_S);
	// Measurement sequencer states.
	typedef enum logic {
		MS_IDLE,
		MS_BUSY
	} wtm_mstate_t;
endpackage
`default_nettype wire

// ---- verilog/wtm_regs.sv ----
// Purpose: Wake-up timer, amplitude wake compare and status registers.
// Assumes: All inputs synchronous to clock; measurements done outside.
// Notes:   Read data appear one cycle after the read strobe, else zero.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module wtm_regs
	import wtm_pkg::*;
#(
	parameter int STEP_LONG = wtm_pkg::STEP_LONG_CYC, // Cycles per long step.
	parameter int STEP_SHRT = wtm_pkg::STEP_SHRT_CYC, // Cycles per short step.
	parameter int PRE_W     = 23                      // Prescaler width.
) (
	input  wire logic                        clock,            // System clock.
	input  wire logic                        reset_n,          // Async reset.
	input  wire logic [wtm_pkg::ADDR_W-1:0]  reg_addr,         // Address.
	input  wire logic [wtm_pkg::DATA_W-1:0]  reg_wdata,        // Write data.
	input  wire logic                        reg_wr,           // Write strobe.
	input  wire logic                        reg_rd,           // Read strobe.
	output logic      [wtm_pkg::DATA_W-1:0]  reg_rdata,        // Read data.
	input  wire logic                        set_default,      // Default cmd.
	input  wire logic [3:0]                  gain_cut_amplitude_chan, // AM.
	input  wire logic [3:0]                  gain_cut_phase_chan,     // PM.
	input  wire logic                        chan_is_phase,    // PM chosen.
	input  wire logic                        field_detected,   // Field seen.
	input  wire logic                        tx_active,        // Sending.
	input  wire logic                        osc_stable,       // Xtal ok.
	input  wire logic                        rx_enabled,       // Decoder on.
	input  wire logic                        rx_receiving,     // In message.
	input  wire logic                        peer_detect_active, // Peer mode.
	input  wire logic                        collision_avoid_active, // Avoid.
	output logic                             amp_meas_start,   // Start pulse.
	input  wire logic                        amp_meas_done,    // Result valid.
	input  wire logic [7:0]                  amp_meas_value,   // Result.
	output logic                             phase_meas_start, // Start pulse.
	input  wire logic                        phase_meas_done,  // Result valid.
	input  wire logic                        phase_over_delta, // Beyond delta.
	output logic                             wake_irq          // Event pulse.
);
	import wtm_pkg::*;

	// Whole state of the block in one record.
	typedef struct packed {
		logic [7:0]       ctrl;   // Wake-up timer control.
		logic [7:0]       acfg;   // Amplitude configuration.
		logic [7:0]       aref;   // Stored amplitude reference.
		logic [7:0]       gain;   // Gain reduction state.
		logic [7:0]       aux;    // Auxiliary status.
		logic [PRE_W-1:0] pre;    // Cycles within the current step.
		logic [2:0]       stp;    // Steps elapsed in the period.
		wtm_mstate_t      mst;    // Measurement sequencer.
		logic             apend;  // Amplitude result awaited.
		logic             ppend;  // Phase result awaited.
		logic [7:0]       avg;    // Amplitude auto-average.
		logic             irq;    // Interrupt pulse.
		logic             astart; // Amplitude start pulse.
		logic             pstart; // Phase start pulse.
		logic [7:0]       rdata;  // Read data.
	} wtm_state_t;

	wtm_state_t s_ff;   // Registered state.
	wtm_state_t nxt_s;  // Next state.

	logic [PRE_W-1:0] step_last;  // Last prescaler count of a step.
	logic             run;        // Timer has work to do.
	logic             pre_last;   // Step ends this cycle.
	logic             expiry;     // Period ends this cycle.
	logic [7:0]       ref_val;    // Reference for the amplitude compare.
	logic signed [8:0] ref_diff;  // Result minus reference.
	logic [7:0]       ref_mag;    // Magnitude of that difference.
	logic             amp_over;   // Difference beyond the delta.
	logic signed [8:0] avg_diff;  // Result minus average.
	logic signed [8:0] avg_step;  // Weighted correction.
	logic [2:0]       avg_shift;  // Shift matching the weight.
	logic [7:0]       avg_upd;    // Average after this result.
	logic             amp_take;   // Amplitude result accepted now.

	// Timer step length and expiry detection.
	always_comb begin
		if (s_ff.ctrl[CTRL_RANGE]) begin
			step_last = PRE_W'(STEP_SHRT - 1);
		end else begin
			step_last = PRE_W'(STEP_LONG - 1);
		end
		// Any of the three wake actions keeps the timer counting.
		run = s_ff.ctrl[CTRL_TO_IRQ] | s_ff.ctrl[CTRL_AMP]
			| s_ff.ctrl[CTRL_PH];
		pre_last = run && (s_ff.pre == step_last);
		// Period is the timeout field plus one whole steps.
		expiry = pre_last
			&& (s_ff.stp == s_ff.ctrl[CTRL_TMO_HI:CTRL_TMO_LO]);
	end

	// Amplitude compare against the chosen reference and averaging.
	always_comb begin
		if (s_ff.acfg[ACFG_SEL]) begin
			ref_val = s_ff.avg;
		end else begin
			ref_val = s_ff.aref;
		end
		ref_diff = $signed({1'b0, amp_meas_value})
			- $signed({1'b0, ref_val});
		if (ref_diff < 0) begin
			ref_mag = 8'(-ref_diff);
		end else begin
			ref_mag = 8'(ref_diff);
		end
		// Delta is compared in raw result units.
		amp_over = ref_mag
			> {4'h0, s_ff.acfg[ACFG_DLT_HI:ACFG_DLT_LO]};
		// Newest result moves the average by diff over the weight.
		avg_shift = AVG_SHIFT_BASE
			+ {1'b0, s_ff.acfg[ACFG_WT_HI:ACFG_WT_LO]};
		avg_diff = $signed({1'b0, amp_meas_value})
			- $signed({1'b0, s_ff.avg});
		avg_step = avg_diff >>> avg_shift;
		avg_upd = s_ff.avg + avg_step[7:0];
		amp_take = (s_ff.mst == MS_BUSY) && s_ff.apend && amp_meas_done;
	end

	// Next-state logic for timer, sequencer and register port.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.irq = 1'b0;
		nxt_s.astart = 1'b0;
		nxt_s.pstart = 1'b0;
		nxt_s.rdata = REG_RESET;
		// Status registers follow the live state every cycle except a set-default cycle, which clears them.
		nxt_s.gain = {gain_cut_amplitude_chan,
			gain_cut_phase_chan};
		nxt_s.aux = {chan_is_phase,
			field_detected,
			tx_active,
			osc_stable,
			rx_enabled, rx_receiving,
			peer_detect_active, collision_avoid_active};
		// Timer counting; it restarts after every expiry.
		if (!run || expiry) begin
			nxt_s.pre = '0;
			nxt_s.stp = '0;
		end else if (pre_last) begin
			nxt_s.pre = '0;
			nxt_s.stp = s_ff.stp + 3'h1;
		end else begin
			nxt_s.pre = s_ff.pre + PRE_W'(1);
		end
		// Plain timeout interrupt on every expiry while the timeout interrupt bit is set.
		if (expiry && s_ff.ctrl[CTRL_TO_IRQ]) begin
			nxt_s.irq = 1'b1;
		end
		// Measurement sequencer; an expiry during a run starts nothing.
		unique case (s_ff.mst)
			MS_IDLE: begin
				if (expiry
					&& (s_ff.ctrl[CTRL_AMP] || s_ff.ctrl[CTRL_PH])) begin
					// Both measurements may be started together.
					nxt_s.astart = s_ff.ctrl[CTRL_AMP];
					nxt_s.pstart = s_ff.ctrl[CTRL_PH];
					nxt_s.apend = s_ff.ctrl[CTRL_AMP];
					nxt_s.ppend = s_ff.ctrl[CTRL_PH];
					nxt_s.mst = MS_BUSY;
				end
			end
			MS_BUSY: begin
				// Amplitude result: compare, then maybe average it.
				if (amp_take) begin
					nxt_s.apend = 1'b0;
					if (amp_over) begin
						nxt_s.irq = 1'b1;
					end
					if (!amp_over || s_ff.acfg[ACFG_INCL]) begin
						nxt_s.avg = avg_upd;
					end
				end
				// Phase result: the compare is made outside.
				if (phase_meas_done && s_ff.ppend) begin
					nxt_s.ppend = 1'b0;
					if (phase_over_delta) begin
						nxt_s.irq = 1'b1;
					end
				end
				// Done once nothing is awaited any more.
				if (!nxt_s.apend && !nxt_s.ppend) begin
					nxt_s.mst = MS_IDLE;
				end
			end
		endcase
		// Register writes; read-only and unmapped writes are dropped.
		if (reg_wr) begin
			case (reg_addr)
				OFS_CTRL: begin
					nxt_s.ctrl = reg_wdata;
					nxt_s.ctrl[CTRL_RSVD] = 1'b0;
					// A new setting starts a fresh period.
					nxt_s.pre = '0;
					nxt_s.stp = '0;
				end
				OFS_ACFG: begin
					nxt_s.acfg = reg_wdata;
				end
				OFS_AREF: begin
					nxt_s.aref = reg_wdata;
				end
				default: begin
					nxt_s.rdata = REG_RESET;
				end
			endcase
		end
		// Register reads; reserved and unmapped addresses give zero.
		if (reg_rd) begin
			case (reg_addr)
				OFS_GAIN: nxt_s.rdata = s_ff.gain;
				OFS_RSVA: nxt_s.rdata = REG_RESET;
				OFS_RSVB: nxt_s.rdata = REG_RESET;
				OFS_AUX:  nxt_s.rdata = s_ff.aux;
				OFS_CTRL: nxt_s.rdata = s_ff.ctrl;
				OFS_ACFG: nxt_s.rdata = s_ff.acfg;
				OFS_AREF: nxt_s.rdata = s_ff.aref;
				default:  nxt_s.rdata = REG_RESET;
			endcase
		end
		// Set-default command returns everything but the read data to its reset state.
		if (set_default) begin
			nxt_s.ctrl = REG_RESET;
			nxt_s.acfg = REG_RESET;
			nxt_s.aref = REG_RESET;
			nxt_s.gain = REG_RESET;
			nxt_s.aux = REG_RESET;
			nxt_s.avg = REG_RESET;
			nxt_s.pre = '0;
			nxt_s.stp = '0;
			nxt_s.mst = MS_IDLE;
			nxt_s.apend = 1'b0;
			nxt_s.ppend = 1'b0;
			nxt_s.astart = 1'b0;
			nxt_s.pstart = 1'b0;
			nxt_s.irq = 1'b0;
		end
	end

	// State register with asynchronous reset to constants.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			s_ff <= '{ctrl: REG_RESET, acfg: REG_RESET, aref: REG_RESET,
				gain: REG_RESET, aux: REG_RESET, pre: '0, stp: '0,
				mst: MS_IDLE, apend: 1'b0, ppend: 1'b0,
				avg: REG_RESET, irq: 1'b0, astart: 1'b0,
				pstart: 1'b0, rdata: REG_RESET};
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Outputs come straight from the state record.
	assign reg_rdata = s_ff.rdata;
	assign amp_meas_start = s_ff.astart;
	assign phase_meas_start = s_ff.pstart;
	assign wake_irq = s_ff.irq;

	// Checks run on the system clock and rest during reset.
	default clocking wtm_cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// Prescaler never passes the last count of the chosen step.
	AST_STEP_BOUND: assert property (
		s_ff.pre <= step_last
	) else $error("prescaler exceeded step length");

	// Timeout interrupt follows an expiry by one cycle.
	AST_TIMEOUT_IRQ: assert property (
		(expiry && s_ff.ctrl[CTRL_TO_IRQ] && !set_default) |=> wake_irq
	) else $error("missing timeout interrupt");

	// Amplitude measurement starts one cycle after an idle expiry.
	AST_AMP_START: assert property (
		(expiry && s_ff.ctrl[CTRL_AMP] && s_ff.mst == MS_IDLE
			&& !set_default) |=> amp_meas_start ##1 !amp_meas_start
	) else $error("amplitude start not a single pulse");

	// Phase measurement starts one cycle after an idle expiry.
	AST_PH_START: assert property (
		(expiry && s_ff.ctrl[CTRL_PH] && s_ff.mst == MS_IDLE
			&& !set_default) |=> phase_meas_start
	) else $error("phase start missing");

	// A result beyond the delta raises the interrupt.
	AST_AMP_IRQ: assert property (
		(amp_take && amp_over && !set_default) |=> wake_irq
	) else $error("amplitude over delta without interrupt");

	// An excluded triggering result leaves the average alone.
	AST_AVG_EXCL: assert property (
		(amp_take && amp_over && !s_ff.acfg[ACFG_INCL] && !set_default)
			|=> $stable(s_ff.avg)
	) else $error("excluded result changed the average");

	// Set-default clears the configuration registers next cycle.
	AST_DEFAULT: assert property (
		set_default |=> (s_ff.ctrl == REG_RESET && s_ff.acfg == REG_RESET
			&& s_ff.aref == REG_RESET)
	) else $error("configuration not cleared by default command");

	// Status registers read zero right after set-default.
	AST_STATUS_CLR: assert property (
		set_default |=> (s_ff.gain == REG_RESET && s_ff.aux == REG_RESET)
	) else $error("status not cleared by default command");

	// Channel select and amplitude gain-cut bits track their inputs one cycle late.
	AST_AUX_TRACK: assert property (
		!set_default |=> (s_ff.aux[7] == $past(chan_is_phase)
			&& s_ff.gain[7:4] == $past(gain_cut_amplitude_chan))
	) else $error("status does not track inputs");

	// Control bit 0 always reads back zero.
	AST_RSVD_BIT: assert property (
		(reg_rd && reg_addr == OFS_CTRL) |=> !reg_rdata[CTRL_RSVD]
	) else $error("reserved control bit read as one");

	// After an expiry the period starts over from zero.
	AST_RESTART: assert property (
		expiry |=> (s_ff.pre == '0 && s_ff.stp == '0)
	) else $error("timer did not restart after expiry");

	// Reads of the reserved locations return zero.
	AST_RSVD_READ: assert property (
		(reg_rd && (reg_addr == OFS_RSVA || reg_addr == OFS_RSVB))
			|=> reg_rdata == REG_RESET
	) else $error("reserved location read as nonzero");

	// A write to the stored reference lands in the next cycle.
	AST_AREF_WRITE: assert property (
		(reg_wr && reg_addr == OFS_AREF && !set_default)
			|=> s_ff.aref == $past(reg_wdata)
	) else $error("stored reference write lost");

	// A phase result beyond its delta raises the interrupt.
	AST_PH_IRQ: assert property (
		(s_ff.mst == MS_BUSY && s_ff.ppend && phase_meas_done
			&& phase_over_delta && !set_default) |=> wake_irq
	) else $error("phase over delta without interrupt");

	// With the short range the prescaler stays within the short step.
	AST_SHORT_RANGE: assert property (
		s_ff.ctrl[CTRL_RANGE] |-> s_ff.pre <= PRE_W'(STEP_SHRT - 1)
	) else $error("short range step overrun");

	// A control write starts a fresh period.
	AST_CTRL_RESTART: assert property (
		(reg_wr && reg_addr == OFS_CTRL)
			|=> (s_ff.pre == '0 && s_ff.stp == '0)
	) else $error("control write did not restart the timer");
endmodule
`default_nettype wire

// ---- bench/wtm_regs_tb.sv ----
// Purpose: Self-checking bench for the wake-up timer register block.
// Assumes: Steps shortened to 20 and 5 cycles; bench drives every port.
// Notes:   Outputs are sampled at the edge, before that edge's updates land.
`timescale 1ns/1ps
`default_nettype none
module wtm_regs_tb;
	import wtm_pkg::*;
	localparam int LONG = 20; // Long step in cycles.
	localparam int SHRT = 5;  // Short step in cycles.
	logic       clock = 1'b0;           // System clock.
	logic       reset_n = 1'b0;         // Reset, low active.
	logic [7:0] reg_addr = 8'h00;       // Register address.
	logic [7:0] reg_wdata = 8'h00;      // Write data.
	logic       reg_wr = 1'b0;          // Write strobe.
	logic       reg_rd = 1'b0;          // Read strobe.
	logic [7:0] reg_rdata;              // Read data.
	logic       set_default = 1'b0;     // Default command.
	logic [3:0] gain_am = 4'h0;         // Amplitude channel gain cut.
	logic [3:0] gain_pm = 4'h0;         // Phase channel gain cut.
	logic [7:0] aux = 8'h00;            // Status levels, bit 7 first.
	logic       amp_meas_start;         // Amplitude start pulse.
	logic       amp_meas_done = 1'b0;   // Amplitude result valid.
	logic [7:0] amp_meas_value = 8'h00; // Amplitude result.
	logic       phase_meas_start;       // Phase start pulse.
	logic       phase_meas_done = 1'b0; // Phase result valid.
	logic       phase_over_delta = 1'b0; // Phase beyond delta.
	logic       wake_irq;               // Wake event pulse.
	int         bad_count = 0;          // Mismatches seen.
	int         n_compared = 0;         // Comparisons made.
	int         n;                      // Cycle count scratch.

	// Free-running 50 MHz clock.
	always #10 clock = ~clock;

	wtm_regs #(.STEP_LONG(LONG), .STEP_SHRT(SHRT), .PRE_W(23)) uut (
		.clock, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.set_default, .gain_cut_amplitude_chan(gain_am),
		.gain_cut_phase_chan(gain_pm), .chan_is_phase(aux[7]),
		.field_detected(aux[6]), .tx_active(aux[5]), .osc_stable(aux[4]),
		.rx_enabled(aux[3]), .rx_receiving(aux[2]),
		.peer_detect_active(aux[1]), .collision_avoid_active(aux[0]),
		.amp_meas_start, .amp_meas_done, .amp_meas_value, .phase_meas_start,
		.phase_meas_done, .phase_over_delta, .wake_irq);

	// Prints the verdict and ends the run.
	task automatic tally_and_finish();
		if (bad_count == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Compares a seen value with the expected one.
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A wait ran out of cycles, so the run stops here.
	task automatic give_up();
		bad_count++;
		$display("[FAIL] %0t wait ran out", $time);
		tally_and_finish();
	endtask

	// One write cycle, then an idle cycle so strobes never collide.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask

	// One read cycle; the data stand only in the following cycle.
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		@(posedge clock);
		chk(reg_rdata, exp);
	endtask

	// Pulses the default command for one cycle.
	task automatic dflt();
		set_default <= 1'b1;
		@(posedge clock);
		set_default <= 1'b0;
		@(posedge clock);
	endtask

	// Waits for a start pulse of the chosen measurement.
	task automatic wait_start(input bit ph);
		int i;
		for (i = 0; i < 300; i++) begin
			@(posedge clock);
			if ((ph ? phase_meas_start : amp_meas_start) === 1'b1) break;
		end
		if (i == 300) give_up();
	endtask

	// Counts edges up to the next wake pulse.
	task automatic wait_irq(output int cnt);
		for (cnt = 1; cnt <= 300; cnt++) begin
			@(posedge clock);
			if (wake_irq === 1'b1) break;
		end
		if (cnt > 300) give_up();
	endtask

	// Answers one measurement and checks the wake pulse after it.
	task automatic measure(input bit ph, input logic [7:0] v,
		input logic ov, input logic exp_irq);
		wait_start(ph);
		if (ph) begin
			phase_meas_done <= 1'b1;
			phase_over_delta <= ov;
		end else begin
			amp_meas_done <= 1'b1;
			amp_meas_value <= v;
		end
		@(posedge clock);
		amp_meas_done <= 1'b0;
		phase_meas_done <= 1'b0;
		@(posedge clock);
		chk(wake_irq, exp_irq);
	endtask

	// Every location reads zero after reset; unmapped reads zero too.
	task automatic t_reset();
		for (int a = 8'h2d; a <= 8'h33; a++) begin
			rd(8'(a), 8'h00);
		end
		rd(8'h40, 8'h00);
	endtask

	// Writable fields hold, read-only places ignore writes, default clears.
	task automatic t_regs();
		wr(OFS_CTRL, 8'hff);
		wr(OFS_ACFG, 8'ha5);
		wr(OFS_AREF, 8'h3c);
		wr(OFS_GAIN, 8'hff);
		wr(OFS_RSVA, 8'hff);
		wr(OFS_AUX, 8'hff);
		rd(OFS_CTRL, 8'hfe);
		rd(OFS_ACFG, 8'ha5);
		rd(OFS_AREF, 8'h3c);
		rd(OFS_GAIN, 8'h00);
		rd(OFS_RSVA, 8'h00);
		rd(OFS_AUX, 8'h00);
		dflt();
		rd(OFS_CTRL, 8'h00);
		rd(OFS_ACFG, 8'h00);
		rd(OFS_AREF, 8'h00);
	endtask

	// Status inputs appear in the gain and auxiliary registers.
	task automatic t_status();
		logic [7:0] p [2] = '{8'ha5, 8'h5a};
		for (int i = 0; i < 2; i++) begin
			gain_am <= p[i][7:4];
			gain_pm <= p[i][3:0];
			aux <= p[i];
			@(posedge clock);
			rd(OFS_GAIN, p[i]);
			rd(OFS_AUX, p[i]);
		end
		aux <= 8'h00;
	endtask

	// Timeout pulses repeat with (timeout + 1) steps of the chosen range.
	task automatic t_period();
		logic [7:0] c [4] = '{8'h18, 8'hf8, 8'h88, 8'h08};
		int e [4] = '{2 * LONG, 8 * SHRT, SHRT, LONG};
		for (int i = 0; i < 4; i++) begin
			dflt();
			wr(OFS_CTRL, c[i]);
			wait_irq(n);
			wait_irq(n);
			chk(8'(n), 8'(e[i]));
		end
		dflt();
	endtask

	// Stored reference compare, strictly beyond the delta.
	task automatic t_amp();
		wr(OFS_AREF, 8'h50);
		wr(OFS_ACFG, 8'h30);
		wr(OFS_CTRL, 8'h04);
		measure(1'b0, 8'h54, 1'b0, 1'b1);
		measure(1'b0, 8'h53, 1'b0, 1'b0);
		measure(1'b0, 8'h4c, 1'b0, 1'b1);
		dflt();
	endtask

	// Phase verdict comes from outside; both measurements may run.
	task automatic t_phase();
		wr(OFS_CTRL, 8'h02);
		measure(1'b1, 8'h00, 1'b1, 1'b1);
		measure(1'b1, 8'h00, 1'b0, 1'b0);
		dflt();
		wr(OFS_CTRL, 8'h06);
		wait_start(1'b0);
		chk(phase_meas_start, 1'b1);
		dflt();
	endtask

	// Averaged reference: exclusion of triggering results and weights.
	task automatic t_avg();
		wr(OFS_ACFG, 8'h31);
		wr(OFS_CTRL, 8'h04);
		measure(1'b0, 8'h40, 1'b0, 1'b1);
		measure(1'b0, 8'h02, 1'b0, 1'b0);
		for (int w = 0; w < 4; w++) begin
			dflt();
			wr(OFS_ACFG, 8'h09 | 8'(w << 1));
			wr(OFS_CTRL, 8'h04);
			measure(1'b0, 8'h80, 1'b0, 1'b1);
			measure(1'b0, 8'h80 >> (2 + w), 1'b0, 1'b0);
		end
		dflt();
	endtask

	// Main sequence: reset for six cycles, then each scenario.
	initial begin
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		t_reset();
		t_regs();
		t_status();
		t_period();
		t_amp();
		t_phase();
		t_avg();
		tally_and_finish();
	end
endmodule
`default_nettype wire
